//--- hdl/dapc_map.svh
// register offsets, field positions, reset values and timing counts of the aux protection block
`ifndef DAPC_MAP_SVH
`define DAPC_MAP_SVH
`define DAPC_OFF_CTRL 12'h000
`define DAPC_OFF_DUTY 12'h004
`define DAPC_OFF_STAT 12'h008
`define DAPC_OFF_IRQ_STAT 12'h00c
`define DAPC_OFF_IRQ_MASK 12'h010
`define DAPC_OFF_M2_TIME 12'h014
`define DAPC_OFF_M2_MOTOR 12'h018
`define DAPC_OFF_M2_OVL 12'h01c
`define DAPC_OFF_M2_BOOST 12'h020
`define DAPC_OFF_TERM_FUNC 12'h024
`define DAPC_OFF_OUT_FUNC 12'h028
`define DAPC_OFF_CYCLE 12'h02c
`define DAPC_BRK_LIMIT_RST 1'b1
`define DAPC_DUTY_RST 5'd10
`define DAPC_DUTY_MAX 5'd30
`define DAPC_PCT_SCALE 7'd100
`define DAPC_FUNC_FAN_ALARM 5'd18
`define DAPC_FUNC_FAULT 5'd17
`define DAPC_FUNC_SECOND_MOTOR 5'd12
`define DAPC_CONT_LIMIT_S 15
`define DAPC_CLK_HZ 64'd250000000
`define DAPC_CONT_LIMIT_CYC (`DAPC_CONT_LIMIT_S * `DAPC_CLK_HZ)
`define DAPC_MS_CYC 250000
`define DAPC_M2_ACC_RST 16'd10
`define DAPC_M2_DEC_RST 16'd50
`define DAPC_M2_BASE_RST 9'd60
`define DAPC_M2_VF_RST 2'd0
`define DAPC_M2_BOOST_RST 4'd5
`define DAPC_M2_STALL_RST 8'd150
`define DAPC_M2_OVL1_RST 8'd150
`define DAPC_M2_OVLC_RST 8'd100
`define DAPC_M2_CUR_RST 9'd263
`define DAPC_IRQ_FAN 0
`define DAPC_IRQ_TRIP 1
`define DAPC_IRQ_BRK_CUT 2
`define DAPC_IRQ_REJECT 3
`endif

//--- hdl/dapc_pkg.sv
// types of the aux protection block
`default_nettype none
package dapc_pkg;
    typedef struct packed {
        logic [15:0] accel_time;
        logic [15:0] decel_time;
        logic [8:0] base_freq;
        logic [1:0] vf_pattern;
        logic [3:0] fwd_boost;
        logic [3:0] rev_boost;
        logic [7:0] stall_level;
        logic [7:0] ovl_one_min;
        logic [7:0] ovl_cont;
        logic [8:0] rated_current;
    } dapc_motor_set_t;
    typedef enum logic [1:0] {
        DAPC_BRK_IDLE = 2'b00,
        DAPC_BRK_ON = 2'b01,
        DAPC_BRK_HOLD = 2'b10
    } dapc_brk_state_t;
endpackage
`default_nettype wire

//--- hdl/dapc_sync2.sv
// two-flop synchroniser for a bundle of pin levels
`default_nettype none
module dapc_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end
    assign q = q_reg;
endmodule // dapc_sync2
`default_nettype wire

//--- hdl/dapc_duty.sv
// braking duty meter: cycle timer and decel share in percent
`default_nettype none
`include "dapc_map.svh"
module dapc_duty #(
    parameter int MS_CYC = `DAPC_MS_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // operating phase
    input wire logic decel,
    input wire logic cycle_end,
    // measured duty of the last whole cycle
    output logic [6:0] duty_pct
);
    logic [17:0] ms_cnt_reg, ms_cnt_next;
    logic [31:0] tot_reg, tot_next;
    logic [31:0] dec_reg, dec_next;
    logic [6:0] pct_reg, pct_next;
    logic [38:0] scaled;
    always_comb begin
        ms_cnt_next = ms_cnt_reg + 18'h00001;
        tot_next = tot_reg;
        dec_next = dec_reg;
        pct_next = pct_reg;
        scaled = 39'(dec_reg) * 39'(`DAPC_PCT_SCALE);
        if (ms_cnt_reg == 18'(MS_CYC - 1)) begin
            ms_cnt_next = 18'h00000;
            tot_next = tot_reg + 32'h1;
            if (decel) begin
                dec_next = dec_reg + 32'h1;
            end
        end
        if (cycle_end) begin
            // decel over accel+steady+decel+stop, times 100
            if (tot_reg != 32'h0) begin
                pct_next = 7'(scaled / 39'(tot_reg));
            end
            tot_next = 32'h0;
            dec_next = 32'h0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_reg <= 18'h00000;
            tot_reg <= 32'h0;
            dec_reg <= 32'h0;
            pct_reg <= 7'h00;
        end else begin
            ms_cnt_reg <= ms_cnt_next;
            tot_reg <= tot_next;
            dec_reg <= dec_next;
            pct_reg <= pct_next;
        end
    end
    assign duty_pct = pct_reg;
endmodule // dapc_duty
`default_nettype wire

//--- hdl/dapc_top.sv
// aux protection: braking limit, fan policy, fan fault, second motor set
//
// Design decisions made here: the APB slave port and the register offsets.
`default_nettype none
`include "dapc_map.svh"
// Notes on behaviour
// - limit select 0 unlimited, 1 capped, default 1
// - braking duty 0 to 30 percent, default 10
// - braking never on continuously beyond 15 s
// - duty is decel share of cycle times 100
// - fan policy 0: fan on while powered
// - fan policy 1: fan follows run with power
// - fan policy 1: overtemperature keeps fan running
// - action 0: keep running, function 18 alarms
// - action 1: fan fault stops drive, shows fault
// - on fan trip, function 17 outputs fault
// - second set active while function 12 input on
// - second set holds its own motor values
module dapc_top #(
    parameter longint CONT_LIMIT_CYC = `DAPC_CONT_LIMIT_CYC,
    parameter int MS_CYC = `DAPC_MS_CYC
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins from the power stage and terminals
    input wire logic power_ok,
    input wire logic forward_run,
    input wire logic heatsink_hot,
    input wire logic fan_fault,
    input wire logic braking_request,
    input wire logic decel_phase,
    input wire logic [7:0] input_terminal_level,
    // outputs
    output logic dynamic_braking,
    output logic fan_on,
    output logic drive_stop,
    output logic led_fault_msg,
    output logic output_one,
    output logic output_two,
    output logic second_motor_active,
    output dapc_pkg::dapc_motor_set_t second_motor_set,
    output logic irq
);
    // ****************************************
    // pin synchronisation
    // ****************************************
    logic [13:0] pins_s;
    dapc_sync2 #(.W(14)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({power_ok, forward_run, heatsink_hot, fan_fault, braking_request,
            decel_phase, input_terminal_level}),
        .q(pins_s)
    );
    logic pwr, run, hot, ffault, brk_req, dec;
    logic [7:0] term;
    assign {pwr, run, hot, ffault, brk_req, dec, term} = pins_s;

    // ****************************************
    // registers
    // ****************************************
    logic braking_limit_select_reg, braking_limit_select_next;
    logic [4:0] braking_duty_rate_reg, braking_duty_rate_next;
    logic fan_policy_reg, fan_policy_next;
    logic fan_failure_action_reg, fan_failure_action_next;
    logic cycle_end_reg, cycle_end_next;
    logic [39:0] input_terminal_function_reg, input_terminal_function_next;
    logic [4:0] output_one_function_reg, output_one_function_next;
    logic [4:0] output_two_function_reg, output_two_function_next;
    dapc_pkg::dapc_motor_set_t m2_reg, m2_next;
    logic [3:0] irq_stat_reg, irq_stat_next;
    logic [3:0] irq_mask_reg, irq_mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic tripped_reg, tripped_next;

    logic wr, rd, hit, reject_ev;
    logic [3:0] ev;
    logic [6:0] duty_pct;
    logic brk_cut;
    logic brk_limit_hit;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    function automatic logic known_off(input logic [11:0] a);
        known_off = (a <= `DAPC_OFF_CYCLE) && (a[1:0] == 2'b00);
    endfunction
    assign hit = known_off(paddr);

    // run-time-locked fields only take writes while stopped
    logic stopped;
    assign stopped = !run;

    always_comb begin
        braking_limit_select_next = braking_limit_select_reg;
        braking_duty_rate_next = braking_duty_rate_reg;
        fan_policy_next = fan_policy_reg;
        fan_failure_action_next = fan_failure_action_reg;
        input_terminal_function_next = input_terminal_function_reg;
        output_one_function_next = output_one_function_reg;
        output_two_function_next = output_two_function_reg;
        m2_next = m2_reg;
        irq_mask_next = irq_mask_reg;
        cycle_end_next = 1'b0;
        reject_ev = 1'b0;
        prdata_next = prdata_reg;
        if (wr && hit) begin
            case (paddr)
                `DAPC_OFF_CTRL: begin
                    braking_limit_select_next = pwdata[0];
                    fan_policy_next = pwdata[1];
                    fan_failure_action_next = pwdata[2];
                end
                `DAPC_OFF_DUTY: begin
                    // out-of-range rate is ignored
                    if (pwdata[4:0] <= `DAPC_DUTY_MAX && pwdata[31:5] == 27'h0) begin
                        braking_duty_rate_next = pwdata[4:0];
                    end
                end
                `DAPC_OFF_M2_TIME: begin
                    m2_next.accel_time = pwdata[15:0];
                    m2_next.decel_time = pwdata[31:16];
                end
                `DAPC_OFF_M2_OVL: begin
                    m2_next.ovl_one_min = pwdata[7:0];
                    m2_next.ovl_cont = pwdata[15:8];
                end
                `DAPC_OFF_M2_MOTOR: begin
                    if (stopped) begin
                        m2_next.base_freq = pwdata[8:0];
                        m2_next.vf_pattern = pwdata[10:9];
                        m2_next.stall_level = pwdata[18:11];
                        m2_next.rated_current = pwdata[27:19];
                    end else begin
                        reject_ev = 1'b1;
                    end
                end
                `DAPC_OFF_M2_BOOST: begin
                    if (stopped) begin
                        m2_next.fwd_boost = pwdata[3:0];
                        m2_next.rev_boost = pwdata[7:4];
                    end else begin
                        reject_ev = 1'b1;
                    end
                end
                `DAPC_OFF_TERM_FUNC: begin
                    input_terminal_function_next = {8'h00, pwdata};
                end
                `DAPC_OFF_OUT_FUNC: begin
                    output_one_function_next = pwdata[4:0];
                    output_two_function_next = pwdata[12:8];
                    input_terminal_function_next[39:32] = pwdata[23:16];
                end
                `DAPC_OFF_IRQ_MASK: irq_mask_next = pwdata[3:0];
                `DAPC_OFF_CYCLE: cycle_end_next = pwdata[0];
                default: ;
            endcase
        end
        if (rd) begin
            case (paddr)
                `DAPC_OFF_CTRL: prdata_next = {29'h0, fan_failure_action_reg,
                    fan_policy_reg, braking_limit_select_reg};
                `DAPC_OFF_DUTY: prdata_next = {9'h0, duty_pct, 11'h0, braking_duty_rate_reg};
                `DAPC_OFF_STAT: prdata_next = {24'h0, tripped_reg, second_motor_active,
                    dynamic_braking, fan_on, hot, ffault, run, pwr};
                `DAPC_OFF_IRQ_STAT: prdata_next = {28'h0, irq_stat_reg};
                `DAPC_OFF_IRQ_MASK: prdata_next = {28'h0, irq_mask_reg};
                `DAPC_OFF_M2_TIME: prdata_next = {m2_reg.decel_time, m2_reg.accel_time};
                `DAPC_OFF_M2_MOTOR: prdata_next = {4'h0, m2_reg.rated_current,
                    m2_reg.stall_level, m2_reg.vf_pattern, m2_reg.base_freq};
                `DAPC_OFF_M2_OVL: prdata_next = {16'h0, m2_reg.ovl_cont, m2_reg.ovl_one_min};
                `DAPC_OFF_M2_BOOST: prdata_next = {24'h0, m2_reg.rev_boost, m2_reg.fwd_boost};
                `DAPC_OFF_TERM_FUNC: prdata_next = input_terminal_function_reg[31:0];
                `DAPC_OFF_OUT_FUNC: prdata_next = {8'h0, input_terminal_function_reg[39:32],
                    3'h0, output_two_function_reg, 3'h0, output_one_function_reg};
                default: prdata_next = 32'h0;
            endcase
        end
    end

    // ****************************************
    // braking resistor
    // ****************************************
    dapc_duty #(.MS_CYC(MS_CYC)) u_duty (
        .pclk(pclk),
        .presetn(presetn),
        .decel(dec),
        .cycle_end(cycle_end_reg),
        .duty_pct(duty_pct)
    );
    dapc_pkg::dapc_brk_state_t brk_state_reg, brk_state_next;
    logic [41:0] on_cnt_reg, on_cnt_next;
    assign brk_limit_hit = braking_limit_select_reg && (duty_pct > 7'(braking_duty_rate_reg));
    always_comb begin
        brk_state_next = brk_state_reg;
        on_cnt_next = on_cnt_reg;
        brk_cut = 1'b0;
        case (brk_state_reg)
            dapc_pkg::DAPC_BRK_IDLE: begin
                on_cnt_next = 42'h0;
                if (brk_req && !brk_limit_hit) begin
                    brk_state_next = dapc_pkg::DAPC_BRK_ON;
                end
            end
            dapc_pkg::DAPC_BRK_ON: begin
                on_cnt_next = on_cnt_reg + 42'h1;
                if (!brk_req) begin
                    brk_state_next = dapc_pkg::DAPC_BRK_IDLE;
                end else if (on_cnt_reg >= 42'(CONT_LIMIT_CYC - 1) || brk_limit_hit) begin
                    brk_state_next = dapc_pkg::DAPC_BRK_HOLD;
                    brk_cut = 1'b1;
                end
            end
            dapc_pkg::DAPC_BRK_HOLD: begin
                // stays off until the request drops, so it never restarts mid-stop
                if (!brk_req) begin
                    brk_state_next = dapc_pkg::DAPC_BRK_IDLE;
                end
            end
            default: brk_state_next = dapc_pkg::DAPC_BRK_IDLE;
        endcase
    end

    // ****************************************
    // fan, fault, second motor
    // ****************************************
    logic fan_next, trip_now;
    logic alarm_next, fault_next, m2_sel_next;
    function automatic logic func_hit(input logic [4:0] f, input logic [4:0] code,
                                      input logic act);
        func_hit = (f == code) && act;
    endfunction
    always_comb begin
        if (!fan_policy_reg) begin
            fan_next = pwr;
        end else begin
            fan_next = pwr && (run || hot);
        end
        trip_now = ffault && fan_failure_action_reg;
        tripped_next = tripped_reg || trip_now;
        if (!pwr) begin
            tripped_next = 1'b0;
        end
        alarm_next = ffault && !fan_failure_action_reg;
        fault_next = tripped_next;
        m2_sel_next = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (input_terminal_function_reg[i*5 +: 5] == `DAPC_FUNC_SECOND_MOTOR && term[i]) begin
                m2_sel_next = 1'b1;
            end
        end
        ev[`DAPC_IRQ_FAN] = ffault;
        ev[`DAPC_IRQ_TRIP] = trip_now;
        ev[`DAPC_IRQ_BRK_CUT] = brk_cut;
        ev[`DAPC_IRQ_REJECT] = reject_ev;
        // event wins over the read-clear
        irq_stat_next = ((rd && paddr == `DAPC_OFF_IRQ_STAT) ? 4'h0 : irq_stat_reg) | ev;
    end
    logic fan_reg, alarm_reg, fault_reg, m2_sel_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            braking_limit_select_reg <= `DAPC_BRK_LIMIT_RST;
            braking_duty_rate_reg <= `DAPC_DUTY_RST;
            fan_policy_reg <= 1'b0;
            fan_failure_action_reg <= 1'b0;
            input_terminal_function_reg <= 40'h0;
            output_one_function_reg <= 5'h00;
            output_two_function_reg <= 5'h00;
            m2_reg <= '{`DAPC_M2_ACC_RST, `DAPC_M2_DEC_RST, `DAPC_M2_BASE_RST,
                `DAPC_M2_VF_RST, `DAPC_M2_BOOST_RST, `DAPC_M2_BOOST_RST,
                `DAPC_M2_STALL_RST, `DAPC_M2_OVL1_RST, `DAPC_M2_OVLC_RST, `DAPC_M2_CUR_RST};
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            prdata_reg <= 32'h0;
            cycle_end_reg <= 1'b0;
            tripped_reg <= 1'b0;
            brk_state_reg <= dapc_pkg::DAPC_BRK_IDLE;
            on_cnt_reg <= 42'h0;
            fan_reg <= 1'b0;
            alarm_reg <= 1'b0;
            fault_reg <= 1'b0;
            m2_sel_reg <= 1'b0;
        end else begin
            braking_limit_select_reg <= braking_limit_select_next;
            braking_duty_rate_reg <= braking_duty_rate_next;
            fan_policy_reg <= fan_policy_next;
            fan_failure_action_reg <= fan_failure_action_next;
            input_terminal_function_reg <= input_terminal_function_next;
            output_one_function_reg <= output_one_function_next;
            output_two_function_reg <= output_two_function_next;
            m2_reg <= m2_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            prdata_reg <= prdata_next;
            cycle_end_reg <= cycle_end_next;
            tripped_reg <= tripped_next;
            brk_state_reg <= brk_state_next;
            on_cnt_reg <= on_cnt_next;
            fan_reg <= fan_next;
            alarm_reg <= alarm_next;
            fault_reg <= fault_next;
            m2_sel_reg <= m2_sel_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign dynamic_braking = (brk_state_reg == dapc_pkg::DAPC_BRK_ON) && !tripped_reg;
    assign fan_on = fan_reg;
    assign drive_stop = tripped_reg;
    assign led_fault_msg = tripped_reg;
    assign output_one = func_hit(output_one_function_reg, `DAPC_FUNC_FAN_ALARM, alarm_reg)
        || func_hit(output_one_function_reg, `DAPC_FUNC_FAULT, fault_reg);
    assign output_two = func_hit(output_two_function_reg, `DAPC_FUNC_FAN_ALARM, alarm_reg)
        || func_hit(output_two_function_reg, `DAPC_FUNC_FAULT, fault_reg);
    assign second_motor_active = m2_sel_reg;
    assign second_motor_set = m2_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);
    assign prdata = prdata_reg;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit;
endmodule // dapc_top
`default_nettype wire

//--- verif/dapc_monitor.sv
// port checker of the aux protection block
`default_nettype none
`include "dapc_map.svh"
module dapc_monitor #(
    parameter longint CONT_LIMIT_CYC = 200
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // pins
    input wire logic power_ok,
    input wire logic forward_run,
    input wire logic heatsink_hot,
    input wire logic fan_fault,
    input wire logic [7:0] input_terminal_level,
    // outputs
    input wire logic dynamic_braking,
    input wire logic fan_on,
    input wire logic drive_stop,
    input wire logic led_fault_msg,
    input wire logic output_one,
    input wire logic second_motor_active
);
    // **********
    // shadow of the settings the checks depend on
    // **********
    logic pol, act;
    logic [4:0] of1, f0;
    longint brk_cnt;
    wire logic wr = psel && penable && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol <= 1'b0;
            act <= 1'b0;
            of1 <= 5'h00;
            f0 <= 5'h00;
            brk_cnt <= 0;
        end else begin
            if (wr && paddr == `DAPC_OFF_CTRL) begin
                pol <= pwdata[1];
                act <= pwdata[2];
            end
            if (wr && paddr == `DAPC_OFF_OUT_FUNC) of1 <= pwdata[4:0];
            if (wr && paddr == `DAPC_OFF_TERM_FUNC) f0 <= pwdata[4:0];
            brk_cnt <= dynamic_braking ? brk_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    unmapped_err_a: assert property (psel && penable && paddr > `DAPC_OFF_CYCLE |-> pslverr)
        else $error("no error on unmapped access");
    fan_always_a: assert property ((!pol && power_ok)[*4] |-> fan_on)
        else $error("fan off while powered");
    fan_run_a: assert property ((pol && power_ok && forward_run)[*4] |-> fan_on)
        else $error("fan off while running");
    fan_idle_a: assert property ((pol && !forward_run && !heatsink_hot)[*4] |-> !fan_on)
        else $error("fan on while idle");
    fan_hot_a: assert property ((pol && power_ok && heatsink_hot)[*4] |-> fan_on)
        else $error("fan off while hot");
    brake_cap_a: assert property (brk_cnt <= CONT_LIMIT_CYC)
        else $error("braking on too long");
    fan_alarm_a: assert property ((!act && of1 == 5'h12 && fan_fault)[*4] |-> output_one)
        else $error("no fan alarm output");
    fan_trip_a: assert property ((act && power_ok && fan_fault)[*4] |-> drive_stop)
        else $error("no stop on fan fault");
    led_msg_a: assert property (led_fault_msg == drive_stop)
        else $error("fault message differs from stop");
    set_two_a: assert property ((f0 == 5'h0c && input_terminal_level[0])[*4]
        |-> second_motor_active)
        else $error("second set not active");
endmodule // dapc_monitor
bind dapc_top dapc_monitor #(.CONT_LIMIT_CYC(CONT_LIMIT_CYC)) u_mon (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pslverr, .power_ok, .forward_run, .heatsink_hot,
    .fan_fault, .input_terminal_level, .dynamic_braking, .fan_on, .drive_stop, .led_fault_msg,
    .output_one, .second_motor_active);
`default_nettype wire

//--- verif/dapc_plant.sv
// far-side model: supply, run switch, heat sink, fan and terminals
`default_nettype none
module dapc_plant (
    // clock and fan drive
    input wire logic pclk,
    input wire logic fan_on,
    // pins to the drive
    output logic power_ok,
    output logic forward_run,
    output logic heatsink_hot,
    output logic fan_fault,
    output logic braking_request,
    output logic decel_phase,
    output logic [7:0] input_terminal_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fan_broken;
    initial begin
        {power_ok, forward_run, heatsink_hot, fan_broken, braking_request, decel_phase} = 6'h00;
        input_terminal_level = 8'h00;
    end
    // a seized fan is only noticed while it is commanded to spin
    always @(posedge pclk) fan_fault <= fan_broken && fan_on;
    task automatic set(input logic [5:0] v);
        @(posedge pclk);
        {power_ok, forward_run, heatsink_hot, fan_broken, braking_request, decel_phase} <= v;
    endtask
    task automatic select_m2(input logic on);
        // motor one is brought to rest before the second set is chosen
        if (on && forward_run) begin
            @(posedge pclk);
            forward_run <= 1'b0;
        end
        @(posedge pclk);
        input_terminal_level[0] <= on;
    endtask
endmodule // dapc_plant
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench of the aux protection block
`default_nettype none
`include "dapc_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam longint LIM = 200;
    // {fan expected, pins}, policy 1 from the third entry
    localparam logic [6:0] FAN_TAB [6] = '{7'h60, 7'h00, 7'h20, 7'h70, 7'h68, 7'h20};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, power_ok, forward_run, heatsink_hot, fan_fault, braking_request;
    logic decel_phase, dynamic_braking, fan_on, drive_stop, led_fault_msg, output_one;
    logic output_two, second_motor_active, irq;
    logic [7:0] input_terminal_level;
    dapc_pkg::dapc_motor_set_t second_motor_set, exp_set;
    int error_cnt = 0;
    int n_checks = 0;
    always #2 pclk = ~pclk;
    dapc_top #(.CONT_LIMIT_CYC(LIM), .MS_CYC(4))
        u_dapc_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .power_ok, .forward_run, .heatsink_hot,
        .fan_fault, .braking_request, .decel_phase, .input_terminal_level, .dynamic_braking,
        .fan_on, .drive_stop, .led_fault_msg, .output_one, .output_two, .second_motor_active,
        .second_motor_set, .irq);
    dapc_plant u_dapc_plant (.pclk, .fan_on, .power_ok, .forward_run, .heatsink_hot, .fan_fault,
        .braking_request, .decel_phase, .input_terminal_level);
    // **********
    // bus and check tasks
    // **********
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        conclude;
    end
    // **********
    // tests
    // **********
    initial begin
        wt(8);
        presetn <= 1'b1;
        wt(1);
        exp_set = '{`DAPC_M2_ACC_RST, `DAPC_M2_DEC_RST, `DAPC_M2_BASE_RST, `DAPC_M2_VF_RST,
            `DAPC_M2_BOOST_RST, `DAPC_M2_BOOST_RST, `DAPC_M2_STALL_RST, `DAPC_M2_OVL1_RST,
            `DAPC_M2_OVLC_RST, `DAPC_M2_CUR_RST};
        chk(second_motor_set, exp_set);
        rd(`DAPC_OFF_CTRL);
        chk(r, 32'h1);
        rd(`DAPC_OFF_DUTY);
        chk(r[4:0], `DAPC_DUTY_RST);
        apb(1'b1, `DAPC_OFF_DUTY, 32'h1f);
        rd(`DAPC_OFF_DUTY);
        chk(r[4:0], `DAPC_DUTY_RST);
        apb(1'b1, `DAPC_OFF_DUTY, 32'h1e);
        rd(`DAPC_OFF_DUTY);
        chk(r[4:0], `DAPC_DUTY_MAX);
        rd(12'h030);
        chk(r, 32'h0);
        for (int i = 0; i < 6; i++) begin
            if (i == 2) apb(1'b1, `DAPC_OFF_CTRL, 32'h3);
            u_dapc_plant.set(FAN_TAB[i][5:0]);
            wt(5);
            chk(fan_on, FAN_TAB[i][6]);
        end
        apb(1'b1, `DAPC_OFF_CTRL, 32'h2);
        u_dapc_plant.set(6'h22);
        wt(6);
        chk(dynamic_braking, 1'b1);
        wt(LIM);
        chk(dynamic_braking, 1'b0);
        u_dapc_plant.set(6'h21);
        apb(1'b1, `DAPC_OFF_CYCLE, 32'h1);
        apb(1'b1, `DAPC_OFF_CTRL, 32'h3);
        apb(1'b1, `DAPC_OFF_CYCLE, 32'h1);
        rd(`DAPC_OFF_DUTY);
        chk(r[22:16], `DAPC_PCT_SCALE);
        u_dapc_plant.set(6'h23);
        wt(6);
        chk(dynamic_braking, 1'b0);
        u_dapc_plant.set(6'h30);
        wt(5);
        rd(`DAPC_OFF_IRQ_STAT);
        apb(1'b1, `DAPC_OFF_M2_TIME, 32'h0032_0014);
        apb(1'b1, `DAPC_OFF_M2_OVL, 32'h0000_6478);
        apb(1'b1, `DAPC_OFF_M2_MOTOR, 32'h0000_0050);
        chk(irq, 1'b0);
        apb(1'b1, `DAPC_OFF_IRQ_MASK, 32'h8);
        wt(2);
        chk(irq, 1'b1);
        chk({second_motor_set.accel_time, second_motor_set.ovl_one_min}, 24'h0014_78);
        chk(second_motor_set.base_freq, `DAPC_M2_BASE_RST);
        rd(`DAPC_OFF_IRQ_STAT);
        chk(r[3], 1'b1);
        wt(2);
        chk(irq, 1'b0);
        apb(1'b1, `DAPC_OFF_TERM_FUNC, 32'h0000_000c);
        u_dapc_plant.select_m2(1'b1);
        wt(5);
        chk(second_motor_active, 1'b1);
        apb(1'b1, `DAPC_OFF_M2_MOTOR, 32'h0000_0050);
        chk(second_motor_set.base_freq, 9'h050);
        u_dapc_plant.select_m2(1'b0);
        wt(5);
        chk(second_motor_active, 1'b0);
        apb(1'b1, `DAPC_OFF_CTRL, 32'h0);
        apb(1'b1, `DAPC_OFF_OUT_FUNC, 32'h0000_1112);
        u_dapc_plant.set(6'h24);
        wt(8);
        chk({output_one, drive_stop}, 2'h2);
        apb(1'b1, `DAPC_OFF_CTRL, 32'h4);
        wt(5);
        chk({drive_stop, led_fault_msg}, 2'h3);
        chk(output_two, 1'b1);
        conclude;
    end
endmodule // testbench
`default_nettype wire
